// ===== edge_detect.sv
/*
 * polarity-selectable edge detector for one timer pin
 * assumes the pin is synchronous to the clock
 */
`timescale 1ns/1ps

module edge_detect (
	input  wire logic i_core_clk,
	input  wire logic i_rst_n,
	input  wire logic i_pin,
	input  wire logic i_rising,
	output logic      o_event
);
	logic prev_r;
	logic prev_nxt;
	logic event_r;
	logic event_nxt;

	// ------------------------------------------------------------------------
	// edge compare
	// ------------------------------------------------------------------------
	always_comb begin
		prev_nxt  = i_pin;
		event_nxt = i_rising ? (i_pin & ~prev_r) : (~i_pin & prev_r);
	end

	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			prev_r  <= 1'b0;
			event_r <= 1'b0;
		end else begin
			prev_r  <= prev_nxt;
			event_r <= event_nxt;
		end
	end

	assign o_event = event_r;
endmodule : edge_detect

// ===== pin_stim.sv
/*
 * far-side model: drives timer pins A and B
 * assumes the bench sets the levels; pins change after a clock edge
 */
`timescale 1ns/1ps
module pin_stim (
	input  wire logic i_core_clk,
	input  wire logic i_a_level,
	input  wire logic i_b_level,
	output logic      o_timer_pin_a = 1'b0,
	output logic      o_timer_pin_b = 1'b0
);
	always @(posedge i_core_clk) begin
		o_timer_pin_a <= i_a_level;
		o_timer_pin_b <= i_b_level;
	end
endmodule : pin_stim

// ===== testbench.sv
/*
 * testbench for the timer clock, prescaler and mode block
 * assumes the checker is bound and the pin model sits beside the design
 */
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin err_total++; \
	$display("[ERR] %0t got %h exp %h", $time, g, e); end end
module testbench;
	logic        i_core_clk = 1'b0;
	logic        i_resetn   = 1'b0;
	logic [7:0]  i_addr     = 8'h00;
	logic [31:0] i_wdata    = 32'h0;
	logic        i_wr       = 1'b0;
	logic        i_rd       = 1'b0;
	logic        lvl_a      = 1'b0;
	logic        lvl_b      = 1'b0;
	logic        pin_a, pin_b, tick, c1, c2, ev, oe;
	logic [31:0] rdata, v;
	logic [1:0]  mode;
	logic [7:0]  pst [3] = '{8'h00, 8'h03, 8'hFF};
	int          err_total, comparisons, n_tick, n_c1, n_c2, n_ea;

	pin_stim u_pins (.i_core_clk(i_core_clk), .i_a_level(lvl_a),
		.i_b_level(lvl_b), .o_timer_pin_a(pin_a), .o_timer_pin_b(pin_b));
	timer_clock_mode_config u_dut (.i_core_clk(i_core_clk),
		.i_resetn(i_resetn), .i_addr(i_addr), .i_wdata(i_wdata),
		.i_wr(i_wr), .i_rd(i_rd), .i_timer_pin_a(pin_a),
		.i_timer_pin_b(pin_b), .o_rdata(rdata), .o_timer_tick(tick),
		.o_counter_one_clk(c1), .o_counter_two_clk(c2),
		.o_pin_a_event(ev), .o_pin_a_oe(oe), .o_timer_mode_select(mode));

	initial begin
		forever #5 i_core_clk = ~i_core_clk;
	end

	always @(posedge i_core_clk) begin
		if (tick) n_tick++;
		if (c1) n_c1++;
		if (c2) n_c2++;
		if (ev) n_ea++;
	end

	// ------------------------------------------------------------------
	// bus tasks
	// ------------------------------------------------------------------
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge i_core_clk);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_core_clk);
		i_wr <= 1'b0;
	endtask : wr

	task rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge i_core_clk);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_core_clk);
		i_rd <= 1'b0;
		#1 d = rdata;
	endtask : rd

	task tk(input int n);
		#1 n_tick = 0;
		n_c1 = 0;
		n_c2 = 0;
		n_ea = 0;
		repeat (n) @(posedge i_core_clk);
		#1;
	endtask : tk

	task print_verdict;
		$display("comparisons %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : print_verdict

	initial begin
		#200000 err_total++;
		print_verdict();
	end

	// ------------------------------------------------------------------
	// tests
	// ------------------------------------------------------------------
	initial begin
		repeat (4) @(posedge i_core_clk);
		i_resetn <= 1'b1;
		repeat (3) @(posedge i_core_clk);
		rd(8'h10, v); `CHK(v, 32'h0)
		rd(8'h14, v); `CHK(v, 32'h0)
		rd(8'h1C, v); `CHK(v, 32'h0)
		wr(8'h10, 32'h1A5); rd(8'h10, v); `CHK(v, 32'hA5)
		wr(8'h14, 32'h3F); rd(8'h14, v); `CHK(v, 32'h3F)
		$display("done: registers");
		wr(8'h14, 32'h09);
		wr(8'h18, 32'h82);
		for (int i = 0; i < 3; i++) begin
			wr(8'h10, {24'h0, pst[i]});
			tk(600);
			tk(512);
			`CHK(n_tick, 512 / (pst[i] + 1))
			`CHK(n_c1, 512 / (pst[i] + 1))
			`CHK(n_c2, 512 / (pst[i] + 1))
		end
		$display("done: prescaler");
		wr(8'h14, 32'h01);
		wr(8'h0C, 32'h1234); rd(8'h0C, v); `CHK(v, 32'h1234)
		wr(8'h18, 32'h02);
		wr(8'h0C, 32'h5555); rd(8'h0C, v); `CHK(v, 32'h1234)
		tk(40); tk(40); `CHK(n_tick, 0)
		`CHK(oe, 1'b0)
		wr(8'h10, 32'h0);
		wr(8'h18, 32'h82);
		wr(8'h14, 32'h09);
		tk(50); rd(8'h0C, v); `CHK(v[15:0] < 16'h1234, 1'b1)
		$display("done: counter two");
		for (int m = 0; m < 4; m++) begin
			wr(8'h18, 32'h80 | m);
			tk(3);
			`CHK(mode, m[1:0])
			`CHK(oe, m != 1)
		end
		$display("done: modes");
		for (int p = 0; p < 2; p++) begin
			wr(8'h18, 32'h82 | (p << 2) | (p << 3));
			wr(8'h14, 32'h02);
			tk(6);
			lvl_a <= 1'b1;
			lvl_b <= 1'b1;
			tk(0); tk(8);
			`CHK(n_ea, p)
			`CHK(n_c1, p)
			lvl_a <= 1'b0;
			lvl_b <= 1'b0;
			tk(0); tk(8);
			`CHK(n_ea, 1 - p)
			`CHK(n_c1, 1 - p)
		end
		$display("done: pins");
		wr(8'h14, 32'h03);
		lvl_b <= 1'b1;
		tk(4); tk(10); `CHK(n_c1, 10)
		lvl_b <= 1'b0;
		tk(4); tk(10); `CHK(n_c1, 0)
		$display("done: accumulate");
		wr(8'h10, 32'h03);
		wr(8'h18, 32'h80);
		wr(8'h24, 32'h02);
		wr(8'h10, 32'hFF);
		tk(20); tk(64); `CHK(n_tick, 16)
		wr(8'h24, 32'h03);
		tk(300); tk(512); `CHK(n_tick, 2)
		rd(8'h24, v); `CHK(v, 32'h2)
		$display("done: pulse train");
		print_verdict();
	end
endmodule : testbench

// ===== timer_cfg_chk.sv
/*
 * checker for the timer clock, prescaler and mode block
 * assumes only the top ports are visible; bound after the module
 */
`timescale 1ns/1ps
module timer_cfg_chk (
	input  wire logic        i_core_clk,
	input  wire logic        i_resetn,
	input  wire logic [7:0]  i_addr,
	input  wire logic [31:0] i_wdata,
	input  wire logic        i_wr,
	input  wire logic        i_rd,
	input  wire logic        i_timer_pin_a,
	input  wire logic [31:0] o_rdata,
	input  wire logic        o_timer_tick,
	input  wire logic        o_counter_one_clk,
	input  wire logic        o_counter_two_clk,
	input  wire logic        o_pin_a_event,
	input  wire logic        o_pin_a_oe,
	input  wire logic [1:0]  o_timer_mode_select
);
	logic [5:0] sel_r, sel_nxt;
	logic [7:0] ctl_r, ctl_nxt;
	logic [7:0] ps_r, ps_nxt;
	logic [8:0] gap_r, gap_nxt;
	logic [1:0] seen_r, seen_nxt;
	logic       pt_r, pt_nxt;

	// ------------------------------------------------------------------
	// register shadows and tick gap
	// ------------------------------------------------------------------
	always_comb begin
		sel_nxt = sel_r;
		ctl_nxt = ctl_r;
		ps_nxt = ps_r;
		pt_nxt = pt_r;
		if (i_wr && i_addr == 8'h24) pt_nxt = i_wdata[1];
		if (i_wr && i_addr == 8'h14) sel_nxt = i_wdata[5:0];
		if (i_wr && i_addr == 8'h18) ctl_nxt = i_wdata[7:0];
		if (i_wr && i_addr == 8'h10) ps_nxt = i_wdata[7:0];
		gap_nxt = o_timer_tick ? 9'h001 : gap_r + 9'h001;
		seen_nxt = seen_r;
		if (o_timer_tick && seen_r != 2'h2) seen_nxt = seen_r + 2'h1;
		if (i_wr || !ctl_r[7] || (ctl_r[1:0] == 2'h0 && pt_r))
			seen_nxt = 2'h0;
	end

	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			sel_r <= 6'h00;
			ctl_r <= 8'h00;
			ps_r <= 8'h00;
			gap_r <= 9'h000;
			seen_r <= 2'h0;
			pt_r <= 1'b0;
		end else begin
			sel_r <= sel_nxt;
			ctl_r <= ctl_nxt;
			ps_r <= ps_nxt;
			gap_r <= gap_nxt;
			seen_r <= seen_nxt;
			pt_r <= pt_nxt;
		end
	end

	// ------------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------------
	default clocking cb @(posedge i_core_clk);
	endclocking
	default disable iff (!i_resetn);

	a_rdata_quiet: assert property (
		!$past(i_rd) |-> o_rdata == 32'h0) else $error("stray read data");
	a_c1_stop: assert property (
		sel_r[2:0] == 3'h0 && $past(sel_r[2:0]) == 3'h0
		|-> !o_counter_one_clk) else $error("stopped counter one clocked");
	a_c1_tick: assert property (
		ctl_r[7] && $past(ctl_r[7]) && sel_r[2:0] == 3'h1
		&& $past(sel_r[2:0]) == 3'h1
		|-> o_counter_one_clk == $past(o_timer_tick))
		else $error("counter one clock not from tick");
	a_c2_tick: assert property (
		ctl_r[7] && $past(ctl_r[7]) && sel_r[5:3] == 3'h1
		&& $past(sel_r[5:3]) == 3'h1
		|-> o_counter_two_clk == $past(o_timer_tick))
		else $error("counter two clock not from tick");
	a_c2_stop: assert property (
		sel_r[5:3] == 3'h0 && $past(sel_r[5:3]) == 3'h0
		|-> !o_counter_two_clk) else $error("stopped counter two clocked");
	a_off_quiet: assert property (
		!ctl_r[7] && !$past(ctl_r[7]) && !$past(ctl_r[7], 2)
		|-> !(o_timer_tick | o_counter_one_clk | o_counter_two_clk
		| o_pin_a_oe)) else $error("activity while disabled");
	a_mode_out: assert property (
		ctl_r[1:0] == $past(ctl_r[1:0])
		|-> o_timer_mode_select == ctl_r[1:0]) else $error("mode wrong");
	a_oe_mode: assert property (
		ctl_r[7] == $past(ctl_r[7]) && ctl_r[1:0] == $past(ctl_r[1:0])
		|-> o_pin_a_oe == (ctl_r[7] && ctl_r[1:0] != 2'h1))
		else $error("pin a direction wrong");
	a_tick_gap: assert property (
		o_timer_tick && seen_r == 2'h2 |-> gap_r == {1'b0, ps_r} + 9'h001)
		else $error("tick period wrong");
	a_pin_a_rise: assert property (
		ctl_r[7] && ctl_r[2] && $rose(i_timer_pin_a)
		|-> ##[1:3] o_pin_a_event) else $error("pin a rise missed");
endmodule : timer_cfg_chk

bind timer_clock_mode_config timer_cfg_chk u_chk (.*);

// ===== timer_clock_mode_config.sv
/*
 * prescaler, clock select, mode select and counter two of a dual timer
 * assumes a plain register port, pins synchronous to i_core_clk
 */
`timescale 1ns/1ps
`include "timer_clock_mode_consts.svh"

// Operation
// - reading counter two returns its live 16-bit count
// - counter two is not initialised by reset
// - 8-bit prescale setting writable at any time
// - outside pulse train, new setting used at next prescaler underflow
// - pulse train (mode 0 with external trigger set) applies setting on start or pin B event
// - tick rate is system clock divided by setting plus one
// - counter one select 000b stops, 001b uses prescaled clock
// - select 010b counts pin B events, 011b accumulates; modes 0 and 2 only
// - counter two select 000b stops counter two
// - two-bit mode field selects one of four operating modes
// - pin A edge bit 0 falling, 1 rising
// - pin B edge bit 0 falling, 1 rising
// - unit disabled stops clocks, resets prescaler, blocks counter two writes, pin A input
module timer_clock_mode_config
	import timer_clock_mode_pkg::*;
(
	input  wire logic        i_core_clk,
	input  wire logic        i_resetn,
	input  wire logic [7:0]  i_addr,
	input  wire logic [31:0] i_wdata,
	input  wire logic        i_wr,
	input  wire logic        i_rd,
	input  wire logic        i_timer_pin_a,
	input  wire logic        i_timer_pin_b,
	output logic [31:0]      o_rdata,
	output logic             o_timer_tick,
	output logic             o_counter_one_clk,
	output logic             o_counter_two_clk,
	output logic             o_pin_a_event,
	output logic             o_pin_a_oe,
	output logic [1:0]       o_timer_mode_select
);
	// ------------------------------------------------------------------------
	// reset release
	// ------------------------------------------------------------------------
	logic [1:0] rst_sync_r;
	logic       rst_n;

	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			rst_sync_r <= 2'h0;
		end else begin
			rst_sync_r <= {rst_sync_r[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_r[1];

	// ------------------------------------------------------------------------
	// registers and decode
	// ------------------------------------------------------------------------
	logic [7:0]  prescale_setting_r;
	logic [7:0]  prescale_setting_nxt;
	logic [7:0]  clock_select_r;
	logic [7:0]  clock_select_nxt;
	logic [7:0]  mode_ctrl_r;
	logic [7:0]  mode_ctrl_nxt;
	logic        pt_ext_trig_r;
	logic        pt_ext_trig_nxt;
	logic        wr_prescale;
	logic        wr_csel;
	logic        wr_mode;
	logic        wr_pt;
	logic        pulse_train_start;
	logic        unit_enable;
	logic [2:0]  counter_one_clock_select;
	logic [2:0]  counter_two_clock_select;
	timer_mode_t timer_mode_select;
	logic        pin_a_edge_polarity;
	logic        pin_b_edge_polarity;

	assign wr_prescale = i_wr && (i_addr == `OFS_PRESCALE_RATIO);
	assign wr_csel     = i_wr && (i_addr == `OFS_CLOCK_SELECT);
	assign wr_mode     = i_wr && (i_addr == `OFS_MODE_CONTROL);
	assign wr_pt       = i_wr && (i_addr == `OFS_PULSE_TRAIN);
	assign pulse_train_start = wr_pt && i_wdata[`PT_START_BIT];
	assign unit_enable = mode_ctrl_r[`UNIT_ENABLE_BIT];
	assign counter_one_clock_select =
		clock_select_r[`CSEL1_LSB +: 3];
	assign counter_two_clock_select =
		clock_select_r[`CSEL2_LSB +: 3];
	assign timer_mode_select =
		timer_mode_t'(mode_ctrl_r[`MODE_LSB +: 2]);
	assign pin_a_edge_polarity = mode_ctrl_r[`PIN_A_EDGE_BIT];
	assign pin_b_edge_polarity = mode_ctrl_r[`PIN_B_EDGE_BIT];

	always_comb begin
		prescale_setting_nxt = prescale_setting_r;
		clock_select_nxt     = clock_select_r;
		mode_ctrl_nxt        = mode_ctrl_r;
		pt_ext_trig_nxt      = pt_ext_trig_r;
		if (wr_prescale) begin
			prescale_setting_nxt = i_wdata[7:0];
		end
		if (wr_csel) begin
			clock_select_nxt = {2'h0, i_wdata[5:0]};
		end
		if (wr_mode) begin
			mode_ctrl_nxt = i_wdata[7:0];
		end
		if (wr_pt) begin
			pt_ext_trig_nxt = i_wdata[`PT_EXT_TRIG_BIT];
		end
	end

	always_ff @(posedge i_core_clk or negedge rst_n) begin
		if (!rst_n) begin
			prescale_setting_r <= `PRESCALE_RESET;
			clock_select_r     <= `CTRL_RESET;
			mode_ctrl_r        <= `CTRL_RESET;
			pt_ext_trig_r      <= 1'b0;
		end else begin
			prescale_setting_r <= prescale_setting_nxt;
			clock_select_r     <= clock_select_nxt;
			mode_ctrl_r        <= mode_ctrl_nxt;
			pt_ext_trig_r      <= pt_ext_trig_nxt;
		end
	end

	// ------------------------------------------------------------------------
	// pin edges
	// ------------------------------------------------------------------------
	logic pin_a_event;
	logic pin_b_event;

	edge_detect u_edge_a (
		.i_core_clk (i_core_clk),
		.i_rst_n    (rst_n),
		.i_pin      (i_timer_pin_a),
		.i_rising   (pin_a_edge_polarity),
		.o_event    (pin_a_event)
	);

	edge_detect u_edge_b (
		.i_core_clk (i_core_clk),
		.i_rst_n    (rst_n),
		.i_pin      (i_timer_pin_b),
		.i_rising   (pin_b_edge_polarity),
		.o_event    (pin_b_event)
	);

	// ------------------------------------------------------------------------
	// prescaler
	// ------------------------------------------------------------------------
	prescale_state_t ps_state_r;
	prescale_state_t ps_state_nxt;
	logic [7:0]      ps_count_r;
	logic [7:0]      ps_count_nxt;
	logic [7:0]      ps_active_r;
	logic [7:0]      ps_active_nxt;
	logic            tick_r;
	logic            tick_nxt;
	logic            pulse_train;
	logic            pt_reload;
	logic            underflow;

	assign pulse_train = (timer_mode_select == MODE_PWM_PULSE_TRAIN)
		&& pt_ext_trig_r;
	assign pt_reload = pulse_train_start
		|| (pt_ext_trig_r && pin_b_event);
	assign underflow = (ps_count_r == `PRESCALE_ZERO);

	always_comb begin
		ps_state_nxt  = ps_state_r;
		ps_count_nxt  = ps_count_r;
		ps_active_nxt = ps_active_r;
		tick_nxt      = 1'b0;
		case (ps_state_r)
		PS_IDLE: begin
			if (unit_enable) begin
				ps_state_nxt  = PS_RUN;
				ps_active_nxt = prescale_setting_r;
				ps_count_nxt  = prescale_setting_r;
			end
		end
		PS_RUN: begin
			if (!unit_enable) begin
				ps_state_nxt  = PS_IDLE;
				ps_count_nxt  = `PRESCALE_ZERO;
				ps_active_nxt = `PRESCALE_ZERO;
			end else if (pulse_train && pt_reload) begin
				ps_active_nxt = prescale_setting_r;
				ps_count_nxt  = prescale_setting_r;
			end else if (underflow) begin
				tick_nxt = 1'b1;
				if (pulse_train) begin
					ps_count_nxt = ps_active_r;
				end else begin
					ps_active_nxt = prescale_setting_r;
					ps_count_nxt  = prescale_setting_r;
				end
			end else begin
				ps_count_nxt = ps_count_r - `PRESCALE_ONE;
			end
		end
		default: begin
			ps_state_nxt = PS_IDLE;
		end
		endcase
	end

	always_ff @(posedge i_core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ps_state_r  <= PS_IDLE;
			ps_count_r  <= `PRESCALE_ZERO;
			ps_active_r <= `PRESCALE_ZERO;
			tick_r      <= 1'b0;
		end else begin
			ps_state_r  <= ps_state_nxt;
			ps_count_r  <= ps_count_nxt;
			ps_active_r <= ps_active_nxt;
			tick_r      <= tick_nxt;
		end
	end

	// ------------------------------------------------------------------------
	// counter clock selection
	// ------------------------------------------------------------------------
	logic c1_clk_nxt;
	logic c2_clk_nxt;
	logic c1_clk_r;
	logic c2_clk_r;
	logic ext_modes;

	assign ext_modes = (timer_mode_select == MODE_PWM_PULSE_TRAIN)
		|| (timer_mode_select == MODE_DUAL_COUNTER);

	always_comb begin
		c1_clk_nxt = 1'b0;
		case (counter_one_clock_select)
		`CSEL_STOP:       c1_clk_nxt = 1'b0;
		`CSEL_PRESCALED:  c1_clk_nxt = tick_r;
		`CSEL_PIN_B:      c1_clk_nxt = ext_modes && pin_b_event;
		`CSEL_ACCUMULATE: c1_clk_nxt = ext_modes && tick_r
			&& i_timer_pin_b;
		default:          c1_clk_nxt = 1'b0;
		endcase
		if (counter_two_clock_select == `CSEL_STOP) begin
			c2_clk_nxt = 1'b0;
		end else begin
			c2_clk_nxt = tick_r;
		end
		if (!unit_enable) begin
			c1_clk_nxt = 1'b0;
			c2_clk_nxt = 1'b0;
		end
	end

	always_ff @(posedge i_core_clk or negedge rst_n) begin
		if (!rst_n) begin
			c1_clk_r <= 1'b0;
			c2_clk_r <= 1'b0;
		end else begin
			c1_clk_r <= c1_clk_nxt;
			c2_clk_r <= c2_clk_nxt;
		end
	end

	// ------------------------------------------------------------------------
	// counter two
	// ------------------------------------------------------------------------
	logic [15:0] counter_two_r;
	logic [15:0] counter_two_nxt;

	always_comb begin
		counter_two_nxt = counter_two_r;
		if (i_wr && (i_addr == `OFS_SECOND_COUNTER) && unit_enable) begin
			counter_two_nxt = i_wdata[15:0];
		end else if (c2_clk_r) begin
			counter_two_nxt = counter_two_r - `COUNT_ONE;
		end
	end

	always_ff @(posedge i_core_clk) begin
		counter_two_r <= counter_two_nxt;
	end

	// ------------------------------------------------------------------------
	// read port and outputs
	// ------------------------------------------------------------------------
	logic [31:0] rdata_nxt;
	logic [31:0] rdata_r;
	logic        pin_a_oe_nxt;
	logic        pin_a_oe_r;
	logic        pin_a_ev_r;

	always_comb begin
		rdata_nxt = `ZERO_WORD;
		if (i_rd) begin
			case (i_addr)
			`OFS_SECOND_COUNTER: rdata_nxt = {16'h0, counter_two_r};
			`OFS_PRESCALE_RATIO: rdata_nxt = {24'h0, prescale_setting_r};
			`OFS_CLOCK_SELECT:   rdata_nxt = {24'h0, clock_select_r};
			`OFS_MODE_CONTROL:   rdata_nxt = {24'h0, mode_ctrl_r};
			`OFS_PULSE_TRAIN:    rdata_nxt = {30'h0, pt_ext_trig_r, 1'b0};
			default:             rdata_nxt = `ZERO_WORD;
			endcase
		end
		pin_a_oe_nxt = unit_enable
			&& (timer_mode_select != MODE_DUAL_CAPTURE);
	end

	always_ff @(posedge i_core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_r    <= `ZERO_WORD;
			pin_a_oe_r <= 1'b0;
			pin_a_ev_r <= 1'b0;
		end else begin
			rdata_r    <= rdata_nxt;
			pin_a_oe_r <= pin_a_oe_nxt;
			pin_a_ev_r <= pin_a_event && unit_enable;
		end
	end

	assign o_rdata             = rdata_r;
	assign o_timer_tick        = tick_r;
	assign o_counter_one_clk   = c1_clk_r;
	assign o_counter_two_clk   = c2_clk_r;
	assign o_pin_a_event       = pin_a_ev_r;
	assign o_pin_a_oe          = pin_a_oe_r;
	assign o_timer_mode_select = mode_ctrl_r[`MODE_LSB +: 2];
endmodule : timer_clock_mode_config

// ===== timer_clock_mode_consts.svh
/*
 * constants for the timer clock, prescaler and mode block
 * assumes word-aligned byte offsets on a plain register port
 */
`ifndef TIMER_CLOCK_MODE_CONSTS_SVH
`define TIMER_CLOCK_MODE_CONSTS_SVH

// ----------------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------------
`define OFS_COUNTER_ONE       8'h00
`define OFS_SECOND_COUNTER    8'h0C
`define OFS_PRESCALE_RATIO    8'h10
`define OFS_CLOCK_SELECT      8'h14
`define OFS_MODE_CONTROL      8'h18
`define OFS_PULSE_TRAIN       8'h24

// ----------------------------------------------------------------------------
// field positions and codes
// ----------------------------------------------------------------------------
`define CSEL1_LSB             0
`define CSEL2_LSB             3
`define MODE_LSB              0
`define PIN_A_EDGE_BIT        2
`define PIN_B_EDGE_BIT        3
`define UNIT_ENABLE_BIT       7
`define PT_START_BIT          0
`define PT_EXT_TRIG_BIT       1
`define CSEL_STOP             3'h0
`define CSEL_PRESCALED        3'h1
`define CSEL_PIN_B            3'h2
`define CSEL_ACCUMULATE       3'h3
`define PRESCALE_RESET        8'h00
`define CTRL_RESET            8'h00
`define ZERO_WORD             32'h0000_0000
`define COUNT_ONE             16'h0001
`define COUNT_ZERO            16'h0000
`define PRESCALE_ZERO         8'h00
`define PRESCALE_ONE          8'h01

`endif

// ===== timer_clock_mode_pkg.sv
/*
 * types for the timer clock, prescaler and mode block
 * assumes the constants header is included by the users
 */
package timer_clock_mode_pkg;

	// ------------------------------------------------------------------------
	// modes and prescaler states
	// ------------------------------------------------------------------------
	typedef enum logic [1:0] {
		MODE_PWM_PULSE_TRAIN = 2'h0,
		MODE_DUAL_CAPTURE    = 2'h1,
		MODE_DUAL_COUNTER    = 2'h2,
		MODE_TIMER_CAPTURE   = 2'h3
	} timer_mode_t;

	typedef enum logic [1:0] {
		PS_IDLE = 2'h1,
		PS_RUN  = 2'h2
	} prescale_state_t;

endpackage : timer_clock_mode_pkg
